// ---- common/mmd_mem_if.sv ----
// Purpose: Port between the register bank and the manageable-device register store.
// Assumes: One access per cycle, read data one cycle after the address.
// Notes: None.
`timescale 1ns/1ps
interface mmd_mem_if;
  import phy_regs_pkg::*;
  logic we;
  mem_index_t index;
  word_t wdata;
  word_t rdata;
  modport ctrl (output we, output index, output wdata, input rdata);
  modport mem (input we, input index, input wdata, output rdata);
endinterface

// ---- common/phy_regs_map.svh ----
// Purpose: Offsets, field positions and reset values of the per-port PHY register bank.
// Assumes: Byte address is four times the register index, index = {port, offset}.
// Notes: Ports are numbered 1 and 2 in the address; port 1 maps to lane 0.
`ifndef PHY_REGS_MAP_SVH
`define PHY_REGS_MAP_SVH

`define IDX_LOCAL_NP 12'h10E
`define IDX_PARTNER_NP 12'h110
`define IDX_SETUP 12'h11A
`define IDX_DATA 12'h11C
`define IDX_LOOP 12'h122
`define PORT_FIRST 4'h1
`define PORT_LAST 4'h2

`define RST_LOCAL_NP 16'h2001
`define RST_PARTNER_NP 16'h0000
`define RST_SETUP 16'h0000
`define RST_DATA 16'h0000
`define RST_LOOP 16'h00F4

`define NP_NEXT_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_ACK2_BIT 12
`define NP_TOGGLE_BIT 11

`define OP_MSB 15
`define OP_LSB 14
`define DEV_MSB 4
`define OP_ADDR 2'h0
`define OP_DATA 2'h1
`define OP_INC_RW 2'h2
`define OP_INC_WR 2'h3

`define LOOP_EN_BIT 8
`define LOOP_RC_BIT 1
`define LOOP_RO_BIT 0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- common/phy_regs_pkg.sv ----
// Purpose: Types shared by the PHY register bank modules.
// Assumes: Constants live in phy_regs_map.svh.
// Notes: None.
package phy_regs_pkg;
  typedef logic [15:0] word_t;
  typedef logic [17:0] axi_addr_t;
  typedef logic [5:0] mem_index_t;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_LOCAL_NP, SEL_PARTNER_NP, SEL_SETUP, SEL_DATA, SEL_LOOP
  } reg_sel_t;
  typedef enum logic [0:0] {WR_IDLE, WR_RESP} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_t;
endpackage

// ---- hdl/line_loop.sv ----
// Purpose: Per-port line path with the remote loopback turn-around.
// Assumes: Receive pins are asynchronous to CLK and pass two flip-flops first.
// Notes: The fabric sees idle nibbles while a port is looped.
`timescale 1ns/1ps
module line_loop (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [1:0] loop_en,
  input wire logic [1:0][3:0] rx_pin,
  input wire logic [1:0][3:0] fabric_tx,
  output logic [1:0][3:0] tx_pin,
  output logic [1:0][3:0] fabric_rx
);
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [3:0] rx_meta_reg;
      logic [3:0] rx_sync_reg;
      logic [3:0] tx_reg;
      logic [3:0] tx_next;
      logic [3:0] frx_reg;
      logic [3:0] frx_next;

      // Looped data turns around here and never reaches the fabric.
      always_comb begin
        tx_next = loop_en[p] ? rx_sync_reg : fabric_tx[p];
        frx_next = loop_en[p] ? 4'h0 : rx_sync_reg;
      end

      always_ff @(posedge CLK) begin
        if (RESET) begin
          rx_meta_reg <= 4'h0;
          rx_sync_reg <= 4'h0;
          tx_reg <= 4'h0;
          frx_reg <= 4'h0;
        end else begin
          rx_meta_reg <= rx_pin[p];
          rx_sync_reg <= rx_meta_reg;
          tx_reg <= tx_next;
          frx_reg <= frx_next;
        end
      end

      assign tx_pin[p] = tx_reg;
      assign fabric_rx[p] = frx_reg;
    end
  endgenerate
endmodule

// ---- hdl/mmd_store.sv ----
// Purpose: Register store standing in for the manageable devices behind indirect access.
// Assumes: Synchronous active-high reset clears every word.
// Notes: Read data come from a register, one cycle after the index.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module mmd_store (
  input wire logic CLK,
  input wire logic RESET,
  mmd_mem_if.mem bus
);
  import phy_regs_pkg::*;
  word_t mem_reg [64];
  word_t mem_next [64];
  word_t rdata_reg;
  word_t rdata_next;

  always_comb begin
    mem_next = mem_reg;
    if (bus.we) begin
      mem_next[bus.index] = bus.wdata;
    end
    rdata_next = mem_reg[bus.index];
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < 64; i++) begin
        mem_reg[i] <= `RST_DATA;
      end
      rdata_reg <= `RST_DATA;
    end else begin
      mem_reg <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus.rdata = rdata_reg;
endmodule

// ---- hdl/phy_np_mmd_regs.sv ----
// Purpose: Per-port next page, indirect device access and remote loopback registers.
// Assumes: AXI4-Lite slave on CLK; next page inputs come from logic on CLK.
// Notes: One write and one read in flight; a write in its execute cycle holds off reads.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module phy_np_mmd_regs (
  input wire logic CLK,
  input wire logic RESET,
  input wire phy_regs_pkg::axi_addr_t S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire phy_regs_pkg::axi_addr_t S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] TX_TOGGLE,
  input wire logic [1:0] PARTNER_PAGE_VALID,
  input wire logic [1:0][15:0] PARTNER_PAGE_WORD,
  output logic [1:0][15:0] LOCAL_PAGE_WORD,
  input wire logic [1:0][3:0] RX_LINE,
  output logic [1:0][3:0] TX_LINE,
  input wire logic [1:0][3:0] FABRIC_TX,
  output logic [1:0][3:0] FABRIC_RX
);
  import phy_regs_pkg::*;

  function automatic reg_sel_t decode(input axi_addr_t a);
    logic [11:0] idx;
    logic [3:0] port;
    idx = a[13:2];
    port = a[17:14];
    decode = SEL_NONE;
    if (a[1:0] == 2'h0 && (port == `PORT_FIRST || port == `PORT_LAST)) begin
      if (idx == `IDX_LOCAL_NP) begin
        decode = SEL_LOCAL_NP;
      end else if (idx == `IDX_PARTNER_NP) begin
        decode = SEL_PARTNER_NP;
      end else if (idx == `IDX_SETUP) begin
        decode = SEL_SETUP;
      end else if (idx == `IDX_DATA) begin
        decode = SEL_DATA;
      end else if (idx == `IDX_LOOP) begin
        decode = SEL_LOOP;
      end
    end
  endfunction

  function automatic mem_index_t mem_index(input logic p, input word_t setup, input word_t addr);
    mem_index = {p, setup[1:0], addr[2:0]};
  endfunction

  function automatic logic post_inc(input word_t setup, input logic is_write);
    post_inc = (setup[`OP_MSB:`OP_LSB] == `OP_INC_RW) ||
               (is_write && setup[`OP_MSB:`OP_LSB] == `OP_INC_WR);
  endfunction

  mmd_mem_if mem_bus ();

  wr_state_t wr_state_reg;
  wr_state_t wr_state_next;
  rd_state_t rd_state_reg;
  rd_state_t rd_state_next;
  logic aw_held_reg;
  logic aw_held_next;
  logic w_held_reg;
  logic w_held_next;
  axi_addr_t awaddr_reg;
  axi_addr_t awaddr_next;
  word_t wdata_reg;
  word_t wdata_next;
  logic [1:0] wstrb_reg;
  logic [1:0] wstrb_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  word_t rdata_reg;
  word_t rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [1:0][15:0] local_np_reg;
  logic [1:0][15:0] local_np_next;
  logic [1:0][15:0] partner_np_reg;
  logic [1:0][15:0] partner_np_next;
  logic [1:0] partner_tog_reg;
  logic [1:0] partner_tog_next;
  logic [1:0][15:0] setup_reg;
  logic [1:0][15:0] setup_next;
  logic [1:0][15:0] mmd_addr_reg;
  logic [1:0][15:0] mmd_addr_next;
  logic [1:0][15:0] loop_reg;
  logic [1:0][15:0] loop_next;
  logic [1:0] loop_en;
  logic wr_exec;
  logic rd_take;
  reg_sel_t wsel;
  reg_sel_t rsel;
  logic wp;
  logic rp;
  word_t wmerge;
  word_t wcur;

  assign wr_exec = (wr_state_reg == WR_IDLE) && aw_held_reg && w_held_reg;
  assign S_AXI_AWREADY = (wr_state_reg == WR_IDLE) && !aw_held_reg;
  assign S_AXI_WREADY = (wr_state_reg == WR_IDLE) && !w_held_reg;
  // A write being executed owns the store this cycle, so reads wait one cycle.
  assign S_AXI_ARREADY = (rd_state_reg == RD_IDLE) && !wr_exec;
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign S_AXI_BVALID = (wr_state_reg == WR_RESP);
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = (rd_state_reg == RD_RESP);
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = {16'h0000, rdata_reg};
  assign wsel = decode(awaddr_reg);
  assign rsel = decode(S_AXI_ARADDR);
  assign wp = awaddr_reg[15];
  assign rp = S_AXI_ARADDR[15];

  always_comb begin
    wcur = 16'h0000;
    unique case (wsel)
      SEL_LOCAL_NP: wcur = local_np_reg[wp];
      SEL_SETUP: wcur = setup_reg[wp];
      SEL_DATA: wcur = mmd_addr_reg[wp];
      SEL_LOOP: wcur = loop_reg[wp];
      SEL_PARTNER_NP, SEL_NONE: wcur = 16'h0000;
    endcase
    wmerge[7:0] = wstrb_reg[0] ? wdata_reg[7:0] : wcur[7:0];
    wmerge[15:8] = wstrb_reg[1] ? wdata_reg[15:8] : wcur[15:8];
  end

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    local_np_next = local_np_reg;
    partner_np_next = partner_np_reg;
    partner_tog_next = partner_tog_reg;
    setup_next = setup_reg;
    mmd_addr_next = mmd_addr_reg;
    loop_next = loop_reg;
    mem_bus.we = 1'b0;
    mem_bus.wdata = wmerge;
    mem_bus.index = mem_index(wp, setup_reg[wp], mmd_addr_reg[wp]);

    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_next = 1'b1;
      wdata_next = S_AXI_WDATA[15:0];
      wstrb_next = S_AXI_WSTRB[1:0];
    end

    unique case (wr_state_reg)
      WR_IDLE: begin
        if (wr_exec) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wr_state_next = WR_RESP;
          bresp_next = `RESP_OKAY;
          unique case (wsel)
            SEL_LOCAL_NP: local_np_next[wp] = wmerge;
            SEL_SETUP: setup_next[wp] = wmerge;
            SEL_DATA: begin
              if (setup_reg[wp][`OP_MSB:`OP_LSB] == `OP_ADDR) begin
                mmd_addr_next[wp] = wmerge;
              end else begin
                mem_bus.we = 1'b1;
                if (post_inc(setup_reg[wp], 1'b1)) begin
                  mmd_addr_next[wp] = mmd_addr_reg[wp] + 16'h0001;
                end
              end
            end
            // Reserved fields keep whatever the host writes back.
            SEL_LOOP: loop_next[wp] = {wmerge[15:1], 1'b0};
            SEL_PARTNER_NP: bresp_next = `RESP_OKAY;
            SEL_NONE: bresp_next = `RESP_SLVERR;
          endcase
        end
      end
      WR_RESP: begin
        if (S_AXI_BREADY) begin
          wr_state_next = WR_IDLE;
        end
      end
    endcase

    unique case (rd_state_reg)
      RD_IDLE: begin
        if (rd_take) begin
          rd_state_next = RD_RESP;
          rresp_next = `RESP_OKAY;
          rdata_next = 16'h0000;
          unique case (rsel)
            SEL_LOCAL_NP: rdata_next = local_np_reg[rp];
            SEL_PARTNER_NP: rdata_next = partner_np_reg[rp];
            SEL_SETUP: rdata_next = setup_reg[rp];
            SEL_DATA: begin
              if (setup_reg[rp][`OP_MSB:`OP_LSB] == `OP_ADDR) begin
                rdata_next = mmd_addr_reg[rp];
              end else begin
                mem_bus.index = mem_index(rp, setup_reg[rp], mmd_addr_reg[rp]);
                rd_state_next = RD_WAIT;
                if (post_inc(setup_reg[rp], 1'b0)) begin
                  mmd_addr_next[rp] = mmd_addr_reg[rp] + 16'h0001;
                end
              end
            end
            SEL_LOOP: begin
              rdata_next = loop_reg[rp];
              loop_next[rp][`LOOP_RC_BIT] = 1'b0;
            end
            SEL_NONE: rresp_next = `RESP_SLVERR;
          endcase
        end
      end
      RD_WAIT: begin
        rdata_next = mem_bus.rdata;
        rd_state_next = RD_RESP;
      end
      RD_RESP: begin
        if (S_AXI_RREADY) begin
          rd_state_next = RD_IDLE;
        end
      end
    endcase

    for (int p = 0; p < 2; p++) begin
      local_np_next[p][`NP_ACK_BIT] = 1'b0;
      local_np_next[p][`NP_TOGGLE_BIT] = TX_TOGGLE[p];
      if (PARTNER_PAGE_VALID[p]) begin
        // Acknowledge and acknowledge-2 are kept as received from the partner.
        partner_np_next[p] = PARTNER_PAGE_WORD[p];
        // Reports the inverse of the toggle carried by the previous page.
        partner_np_next[p][`NP_TOGGLE_BIT] = ~partner_tog_reg[p];
        partner_tog_next[p] = PARTNER_PAGE_WORD[p][`NP_TOGGLE_BIT];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_state_reg <= WR_IDLE;
      rd_state_reg <= RD_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 18'h0_0000;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      bresp_reg <= `RESP_OKAY;
      rdata_reg <= 16'h0000;
      rresp_reg <= `RESP_OKAY;
      local_np_reg <= {2{`RST_LOCAL_NP}};
      partner_np_reg <= {2{`RST_PARTNER_NP}};
      partner_tog_reg <= 2'h0;
      setup_reg <= {2{`RST_SETUP}};
      mmd_addr_reg <= {2{`RST_DATA}};
      loop_reg <= {2{`RST_LOOP}};
    end else begin
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      local_np_reg <= local_np_next;
      partner_np_reg <= partner_np_next;
      partner_tog_reg <= partner_tog_next;
      setup_reg <= setup_next;
      mmd_addr_reg <= mmd_addr_next;
      loop_reg <= loop_next;
    end
  end

  assign LOCAL_PAGE_WORD = local_np_reg;
  assign loop_en = {loop_reg[1][`LOOP_EN_BIT], loop_reg[0][`LOOP_EN_BIT]};

  mmd_store u_store (
    .CLK(CLK),
    .RESET(RESET),
    .bus(mem_bus.mem)
  );

  line_loop u_line (
    .CLK(CLK),
    .RESET(RESET),
    .loop_en(loop_en),
    .rx_pin(RX_LINE),
    .fabric_tx(FABRIC_TX),
    .tx_pin(TX_LINE),
    .fabric_rx(FABRIC_RX)
  );
endmodule

// ---- tb/axi_host.sv ----
// Purpose: Management host model issuing single AXI4-Lite transfers.
// Assumes: Every bus signal changes only just after a rising clock edge.
// Notes: Handshakes and answers are taken at the rising edge at which they stand.
`timescale 1ns/1ps
module axi_host (
  input wire logic CLK,
  output phy_regs_pkg::axi_addr_t S_AXI_AWADDR = 18'h0_0000,
  output logic S_AXI_AWVALID = 1'b0,
  input wire logic S_AXI_AWREADY,
  output logic [31:0] S_AXI_WDATA = 32'h0000_0000,
  output logic [3:0] S_AXI_WSTRB = 4'h0,
  output logic S_AXI_WVALID = 1'b0,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  output logic S_AXI_BREADY = 1'b0,
  output phy_regs_pkg::axi_addr_t S_AXI_ARADDR = 18'h0_0000,
  output logic S_AXI_ARVALID = 1'b0,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  output logic S_AXI_RREADY = 1'b0
);
  import phy_regs_pkg::*;
  task automatic wr(input axi_addr_t a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic b_ok;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      b_ok = S_AXI_BVALID;
      r = S_AXI_BRESP;
    end while (!b_ok);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input axi_addr_t a, output logic [31:0] d, output logic [1:0] r);
    logic r_ok;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      r_ok = S_AXI_RVALID;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
    end while (!r_ok);
    S_AXI_RREADY <= 1'b0;
  endtask
endmodule

// ---- tb/phy_nextpage_mmd_loopback_regs_tb.sv ----
// Purpose: Self-checking bench of the PHY register bank.
// Assumes: Port 1 is lane 0 of the packed line and page buses.
// Notes: Indirect access uses device 1, then device 2 for the last read, so the held address can be followed.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module phy_nextpage_mmd_loopback_regs_tb;
  import phy_regs_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  axi_addr_t S_AXI_AWADDR, S_AXI_ARADDR;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [1:0] TX_TOGGLE = 2'h0;
  logic [1:0] PARTNER_PAGE_VALID = 2'h0;
  logic [1:0][15:0] PARTNER_PAGE_WORD = 32'h0000_0000;
  logic [1:0][15:0] LOCAL_PAGE_WORD;
  logic [1:0][3:0] RX_LINE = 8'h00, FABRIC_TX = 8'h00, TX_LINE, FABRIC_RX;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  phy_np_mmd_regs u_dut (.*);
  axi_host u_host (.*);
  always #2.5 CLK = ~CLK;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic axi_addr_t ad(input logic [3:0] p, input logic [11:0] i);
    return {p, i, 2'b00};
  endfunction
  task automatic w(input logic [3:0] p, input logic [11:0] i, input word_t d);
    logic [1:0] r;
    u_host.wr(ad(p, i), {16'h0000, d}, 4'hF, r);
    chk(32'(r), 32'(`RESP_OKAY));
  endtask
  task automatic rc(input logic [3:0] p, input logic [11:0] i, input word_t e);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(ad(p, i), d, r);
    chk(d, {16'h0000, e});
    chk(32'(r), 32'(`RESP_OKAY));
  endtask
  task automatic pg(input word_t d);
    @(posedge CLK);
    PARTNER_PAGE_VALID <= 2'h2;
    PARTNER_PAGE_WORD[1] <= d;
    @(posedge CLK);
    PARTNER_PAGE_VALID <= 2'h0;
  endtask
  task automatic t_reset;
    for (int p = 1; p <= 2; p++) begin
      rc(p[3:0], `IDX_LOCAL_NP, 16'h2001);
      rc(p[3:0], `IDX_PARTNER_NP, 16'h0000);
      rc(p[3:0], `IDX_SETUP, 16'h0000);
      rc(p[3:0], `IDX_DATA, 16'h0000);
      rc(p[3:0], `IDX_LOOP, 16'h00F4);
    end
  endtask
  task automatic t_local;
    logic [1:0] r;
    @(posedge CLK);
    TX_TOGGLE <= 2'h1;
    w(4'h1, `IDX_LOCAL_NP, 16'hD7FF);
    rc(4'h1, `IDX_LOCAL_NP, 16'h9FFF);
    @(negedge CLK);
    chk(LOCAL_PAGE_WORD, 32'h2001_9FFF);
    @(posedge CLK);
    TX_TOGGLE <= 2'h2;
    w(4'h1, `IDX_LOCAL_NP, 16'h0000);
    rc(4'h1, `IDX_LOCAL_NP, 16'h0000);
    rc(4'h2, `IDX_LOCAL_NP, 16'h2801);
    // Only the low lane is strobed, so the upper byte must keep its stored value.
    u_host.wr(ad(4'h2, `IDX_LOCAL_NP), 32'h0000_80FF, 4'h1, r);
    chk(32'(r), 32'(`RESP_OKAY));
    rc(4'h2, `IDX_LOCAL_NP, 16'h28FF);
  endtask
  task automatic t_partner;
    pg(16'h5800);
    rc(4'h2, `IDX_PARTNER_NP, 16'h5800);
    pg(16'h4000);
    rc(4'h2, `IDX_PARTNER_NP, 16'h4000);
    pg(16'h1000);
    rc(4'h2, `IDX_PARTNER_NP, 16'h1800);
    w(4'h2, `IDX_PARTNER_NP, 16'hFFFF);
    rc(4'h2, `IDX_PARTNER_NP, 16'h1800);
    rc(4'h1, `IDX_PARTNER_NP, 16'h0000);
  endtask
  // The held address is followed through every mode, so each step depends on the last.
  task automatic t_mmd;
    w(4'h1, `IDX_SETUP, 16'h0001);
    w(4'h1, `IDX_DATA, 16'h0003);
    rc(4'h1, `IDX_DATA, 16'h0003);
    w(4'h1, `IDX_SETUP, 16'h4001);
    w(4'h1, `IDX_DATA, 16'hAAAA);
    rc(4'h1, `IDX_DATA, 16'hAAAA);
    rc(4'h1, `IDX_DATA, 16'hAAAA);
    w(4'h1, `IDX_SETUP, 16'h8001);
    rc(4'h1, `IDX_DATA, 16'hAAAA);
    w(4'h1, `IDX_DATA, 16'h1234);
    w(4'h1, `IDX_SETUP, 16'h0001);
    rc(4'h1, `IDX_DATA, 16'h0005);
    w(4'h1, `IDX_SETUP, 16'hC001);
    rc(4'h1, `IDX_SETUP, 16'hC001);
    rc(4'h1, `IDX_DATA, 16'h0000);
    w(4'h1, `IDX_DATA, 16'h5555);
    w(4'h1, `IDX_SETUP, 16'h0001);
    rc(4'h1, `IDX_DATA, 16'h0006);
    w(4'h1, `IDX_DATA, 16'h0004);
    w(4'h1, `IDX_SETUP, 16'h4001);
    rc(4'h1, `IDX_DATA, 16'h1234);
    w(4'h1, `IDX_SETUP, 16'h4002);
    rc(4'h1, `IDX_DATA, 16'h0000);
  endtask
  task automatic t_loop;
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(ad(4'h1, `IDX_LOOP), d, r);
    w(4'h1, `IDX_LOOP, d[15:0] | 16'h0100);
    rc(4'h1, `IDX_LOOP, 16'h01F4);
    @(posedge CLK);
    RX_LINE <= 8'h3A;
    FABRIC_TX <= 8'h65;
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk(TX_LINE, 32'h0000_006A);
    chk(FABRIC_RX, 32'h0000_0030);
    w(4'h1, `IDX_LOOP, 16'h01F7);
    rc(4'h1, `IDX_LOOP, 16'h01F6);
    rc(4'h1, `IDX_LOOP, 16'h01F4);
    w(4'h1, `IDX_LOOP, 16'h00F4);
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk(TX_LINE, 32'h0000_0065);
    chk(FABRIC_RX, 32'h0000_003A);
  endtask
  // Refused accesses must leave the loopback word untouched.
  task automatic t_err;
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(ad(4'h3, `IDX_LOOP), d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(`RESP_SLVERR));
    u_host.wr(ad(4'h1, `IDX_LOOP) | 18'h0_0001, 32'h0000_01FF, 4'hF, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    rc(4'h1, `IDX_LOOP, 16'h00F4);
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    t_reset;
    t_local;
    t_partner;
    t_mmd;
    t_loop;
    t_err;
    end_sim;
  end
endmodule

// ---- tb/phy_regs_checker.sv ----
// Purpose: Bus timing and local page toggle checks on the PHY register bank ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached to the bank by bind at the foot of this file.
`timescale 1ns/1ps
`include "phy_regs_map.svh"
module phy_regs_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [1:0] TX_TOGGLE,
  input wire logic [1:0][15:0] LOCAL_PAGE_WORD
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  b_latency_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write response late or early");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  b_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == `RESP_OKAY || S_AXI_BRESP == `RESP_SLVERR)
    else $error("write response code bad");
  b_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while responding");
  r_latency_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
    else $error("read response late");
  r_busy_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_ARREADY)
    else $error("second read taken in flight");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read response dropped");
  r_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("read data upper half set");
  r_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response repeated");
  local_toggle_a: assert property (
    !$past(RESET) |-> LOCAL_PAGE_WORD[0][11] == $past(TX_TOGGLE[0]))
    else $error("local toggle does not follow transmit toggle");
endmodule
bind phy_np_mmd_regs phy_regs_checker u_chk (.*);
